/* design/mssup_top.sv */
// Purpose: Motor starter supervision: source arbitration, faults, alarms, trip reset
// Assumes: All inputs synchronous to mclk; APB slave for control and status
// Notes:   Device fault from self-test survives trip reset, only sys_rst clears it
//          Every output except the APB ones is registered, so it follows its cause by one mclk
//          Faults are sticky; a cause still present wins over a trip reset
//          The protection fault also clears itself when the run command goes
//          Quick stop is edge triggered on input one and held until the run command goes or it is disabled
//          Software control: CTRL forces manual mode, LOCALCMD stands in for
//          the optical channel's run bits and its reset pulse
//
// Contract
// - Breaker tripped or off raises group fault
// - Automatic mode takes commands from bus only
// - Manual mode uses keypad or optical, optical first
// - Manual mode shows manual-local diagnostic message
// - Check parameters; both protections off not allowed
// - Both protections off, no run: group alarm
// - Both off while running: fault plus shutdown
// - Reset of that fault needs protection re-enabled
// - Run withdrawn downgrades that fault to alarm
// - Ready-automatic only bus-controllable, automatic, faultless
// - Group fault when any fault is set
// - Group alarm when any alarm is present
// - Trip reset clears only acknowledgeable faults
// - Both bus run bits mean trip reset; the code honours them in automatic mode only
// - Key switch off or optical also reset
// - Self-test runs after power-on or initialization
// - Components monitored cyclically, failure is device fault
// - Self-test fault lights red, survives trip reset
// - Quick-stop-disable bit frees input one
`timescale 1ns/1ps
`default_nettype none
`include "mssup_defines.svh"
module mssup_top (
  input  wire logic                   mclk,
  input  wire logic                   sys_rst,
  // APB slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // Output process image from the fieldbus master
  input  wire logic                   bus_cw_on,
  input  wire logic                   bus_ccw_on,
  input  wire logic                   output_bit_two_quickstop_disable,
  input  wire logic                   bus_online,
  // Local sources
  input  wire logic                   key_manual,
  input  wire logic                   key_off,
  input  wire logic                   keypad_cw,
  input  wire logic                   keypad_ccw,
  input  wire logic                   optic_active,
  input  wire logic                   optic_cw,
  input  wire logic                   optic_ccw,
  input  wire logic                   optic_reset,
  // Plant status
  input  wire logic                   breaker_off,
  input  wire logic                   temp_sensor_en,
  input  wire logic                   thermal_class_en,
  input  wire logic                   comp_fail,
  input  wire logic                   selftest_fail,
  input  wire logic                   ext_fault,
  input  wire logic                   input_one,
  // Outputs
  output mssup_pkg::mssup_src_t       ctrl_src,
  output logic                        motor_cw,
  output logic                        motor_ccw,
  output logic                        internal_shutdown,
  output logic                        group_fault,
  output logic                        group_alarm,
  output logic                        device_led_red,
  output logic                        ready_auto,
  output logic                        manual_local_diag,
  output logic                        quickstop_active,
  output logic [1:0]                  input_process_image
);
  import mssup_pkg::*;

  logic [`MSSUP_NFAULT-1:0] fault;
  logic [`MSSUP_NFAULT-1:0] fault_cause;
  logic [`MSSUP_NFAULT-1:0] fault_ackable;
  logic [31:0]              ctrl;
  logic [31:0]              localcmd;
  logic [15:0]              st_cnt;
  mssup_st_t                st;
  mssup_st_t                next_st;
  mssup_src_t               next_src;
  logic                     manual_mode;
  logic                     prot_off;
  logic                     run_req;
  logic                     bus_reset;
  logic                     trip_reset;
  logic                     prot_alarm;
  logic                     src_cw;
  logic                     src_ccw;
  logic                     qs_latch;
  logic                     qs_in_d;
  logic                     dev_fail;
  logic                     apb_wr;
  logic                     addr_ok;

  // Software may hold the starter in manual mode or inject a local reset
  assign manual_mode = key_manual | ctrl[0];
  assign prot_off    = ~temp_sensor_en & ~thermal_class_en;

  // Bus reset combination is never a run command
  assign bus_reset = bus_cw_on & bus_ccw_on;

  // Source arbitration by mode, optical first in manual mode
  // Key switch off overrides every source: no command is obeyed there.
  // Leaving manual mode hands control straight back to the bus master,
  // so a keypad button still held cannot carry over into automatic mode.
  // Selection is purely combinational; ctrl_src shows it one cycle later.
  always_comb begin
    next_src = MSSUP_SRC_NONE;
    if (key_off) begin
      next_src = MSSUP_SRC_NONE;
    end else if (manual_mode) begin
      if (optic_active) begin
        next_src = MSSUP_SRC_OPTIC;
      end else begin
        next_src = MSSUP_SRC_KEYPAD;
      end
    end else begin
      next_src = MSSUP_SRC_BUS;
    end
  end

  // Commands from the selected source only; others are discarded
  // Opposite directions within one pair never reach the motor: the bus pair is a
  // reset request, the local pairs are treated as an operator stop.
  // Software run bits share the optical slot, as a stand-in for that channel.
  always_comb begin
    src_cw  = 1'b0;
    src_ccw = 1'b0;
    unique case (next_src)
      MSSUP_SRC_NONE: begin
        src_cw  = 1'b0;
        src_ccw = 1'b0;
      end
      MSSUP_SRC_BUS: begin
        src_cw  = bus_cw_on & ~bus_reset;
        src_ccw = bus_ccw_on & ~bus_reset;
      end
      MSSUP_SRC_KEYPAD: begin
        // Both buttons together is an operator error: stop
        src_cw  = keypad_cw & ~keypad_ccw;
        src_ccw = keypad_ccw & ~keypad_cw;
      end
      MSSUP_SRC_OPTIC: begin
        src_cw  = optic_cw & ~optic_ccw | localcmd[0] & ~localcmd[1];
        src_ccw = optic_ccw & ~optic_cw | localcmd[1] & ~localcmd[0];
      end
    endcase
  end
  assign run_req = src_cw | src_ccw;

  // Trip reset sources: bus combination, key switch off, optical, software
  // The bus pair only acts in automatic mode, where the bus owns control.
  // All sources but the one-cycle software bit are levels; holding one repeats the acknowledge.
  // Limitation: a held reset also clears a fault the moment its cause goes.
  assign trip_reset = (bus_reset & ~manual_mode) | key_off | optic_reset | localcmd[2];

  // Self-test sequencer: start after reset, then cyclic checking
  // The startup window is a fixed count; a failure inside it is final.
  // In run state component checks are sampled on every clock, so a short
  // glitch on comp_fail is enough to latch a device fault.
  // Illegal codes fall into the failed state rather than silently running.
  always_comb begin
    next_st = st;
    unique case (st)
      MSSUP_ST_START: begin
        if (selftest_fail) begin
          next_st = MSSUP_ST_FAIL;
        end else if (st_cnt == `MSSUP_SELFTEST_CYC) begin
          next_st = MSSUP_ST_RUN;
        end
      end
      MSSUP_ST_RUN: begin
        if (comp_fail) begin
          next_st = MSSUP_ST_FAIL;
        end
      end
      MSSUP_ST_FAIL: begin
        next_st = MSSUP_ST_FAIL;
      end
      default: begin
        next_st = MSSUP_ST_FAIL;
      end
    endcase
  end

  // Only a reset leaves the failed state; trip reset cannot
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st <= MSSUP_ST_START;
    end else begin
      st <= next_st;
    end
  end

  // Counter measures the startup test and the cyclic period
  // It freezes in the failed state so it cannot wrap and hide the failure.
  // The cyclic period only paces the counter; checks are not gated by it.
  // Sixteen bits cover both the startup window and the cyclic period.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_cnt <= 16'h0000;
    end else if (st == MSSUP_ST_RUN && st_cnt == `MSSUP_CYCLIC_CYC) begin
      st_cnt <= 16'h0000;
    end else if (st != MSSUP_ST_FAIL) begin
      st_cnt <= st_cnt + 16'h0001;
    end
  end
  assign dev_fail = (st == MSSUP_ST_FAIL);

  // Fault causes and which are acknowledgeable now
  // A fault may be acknowledged once its cause is gone; the protection
  // fault also when protection is back, even with the run command kept.
  // The device fault is never acknowledgeable: only sys_rst clears it.
  // The external fault is a plain level from outside, with no extra check.
  assign fault_cause[`MSSUP_F_BREAKER] = breaker_off;
  assign fault_cause[`MSSUP_F_PROT]    = prot_off & run_req;
  assign fault_cause[`MSSUP_F_DEVICE]  = dev_fail;
  assign fault_cause[`MSSUP_F_EXT]     = ext_fault;
  assign fault_ackable[`MSSUP_F_BREAKER] = ~breaker_off;
  assign fault_ackable[`MSSUP_F_PROT]    = ~prot_off | ~run_req;
  assign fault_ackable[`MSSUP_F_DEVICE]  = 1'b0;
  assign fault_ackable[`MSSUP_F_EXT]     = ~ext_fault;

  // Sticky faults; a present cause wins over a simultaneous reset
  // Cause first avoids losing a fault that arrives with an acknowledge.
  // The protection bit also drops when the run command goes away.
  // One flip-flop per fault bit, each with its own set and clear terms.
  genvar gi;
  generate
    for (gi = 0; gi < `MSSUP_NFAULT; gi = gi + 1) begin : g_fault
      always_ff @(posedge mclk) begin
        if (sys_rst) begin
          fault[gi] <= 1'b0;
        end else if (fault_cause[gi]) begin
          fault[gi] <= 1'b1;
        end else if (gi == `MSSUP_F_PROT && !run_req) begin
          fault[gi] <= 1'b0;
        end else if (trip_reset && fault_ackable[gi]) begin
          fault[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Protection-off alarm while not running, and after downgrade
  // It drops as soon as either protection function is enabled again.
  assign prot_alarm = prot_off & ~run_req;

  // Quick stop: edge on input one latches, cleared by stop or disable
  // The edge detector idles low like the pin, so reset gives no false edge.
  // A static high input does not retrigger: after a disable the motor keeps
  // running until its command is withdrawn.
  // Quick stop switches the motor off without raising a group fault.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      qs_in_d  <= 1'b0;
      qs_latch <= 1'b0;
    end else begin
      qs_in_d <= input_one;
      if (output_bit_two_quickstop_disable || !run_req) begin
        qs_latch <= 1'b0;
      end else if (input_one && !qs_in_d) begin
        qs_latch <= 1'b1;
      end
    end
  end

  // Registered outputs
  // Registering every output costs one cycle of latency but gives glitch
  // free indicators and a stable status word for software reads.
  // The motor is gated by both the latched faults and the live causes, so
  // the first cycle of a new fault already keeps the motor off.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctrl_src          <= MSSUP_SRC_NONE;
      motor_cw          <= 1'b0;
      motor_ccw         <= 1'b0;
      internal_shutdown <= 1'b0;
      group_fault       <= 1'b0;
      group_alarm       <= 1'b0;
      device_led_red    <= 1'b0;
      ready_auto        <= 1'b0;
      manual_local_diag <= 1'b0;
      quickstop_active  <= 1'b0;
      input_process_image <= 2'b00;
    end else begin
      ctrl_src          <= next_src;
      internal_shutdown <= fault[`MSSUP_F_PROT] | fault_cause[`MSSUP_F_PROT];
      // Any fault or quick stop keeps the motor off
      motor_cw  <= src_cw & ~(|fault) & ~(|fault_cause) & ~qs_latch;
      motor_ccw <= src_ccw & ~(|fault) & ~(|fault_cause) & ~qs_latch;
      group_fault <= |(fault | fault_cause);
      group_alarm <= prot_alarm;
      device_led_red <= dev_fail;
      ready_auto <= bus_online & ~manual_mode & ~key_off & ~(|fault);
      manual_local_diag <= manual_mode;
      quickstop_active  <= qs_latch;
      // Input one reads free when quick stop is disabled
      input_process_image <= {1'b0, input_one & output_bit_two_quickstop_disable};
    end
  end

  // Register map, one aligned 32-bit word each
  //   0x000 CTRL      bit 0 forces manual mode
  //   0x004 STATUS    {ready_auto, manual diag, red led, alarm, fault,
  //                    shutdown, source[1:0]}
  //   0x008 FAULT     {ext, device, protection, breaker}
  //   0x00c ALARM     bit 0 group alarm
  //   0x010 DIAG      {manual local, group alarm, group fault}
  //   0x014 LOCALCMD  bit 0 cw, bit 1 ccw, bit 2 reset pulse
  // Reads of other offsets return zero and flag pslverr; writes there are
  // dropped. There are no byte strobes: a write always replaces the word.
  // APB: zero wait states, unmapped reads zero with error
  assign pready = 1'b1;
  assign apb_wr = psel & penable & pwrite;
  always_comb begin
    addr_ok = 1'b1;
    prdata  = 32'h0000_0000;
    unique case (paddr)
      `MSSUP_ADDR_CTRL:     prdata = ctrl;
      `MSSUP_ADDR_STATUS:   prdata = {24'h000000, ready_auto, manual_local_diag,
                                      device_led_red, group_alarm, group_fault,
                                      internal_shutdown, ctrl_src};
      `MSSUP_ADDR_FAULT:    prdata = {28'h0000000, fault};
      `MSSUP_ADDR_ALARM:    prdata = {31'h00000000, group_alarm};
      `MSSUP_ADDR_DIAG:     prdata = {29'h00000000, manual_local_diag, group_alarm, group_fault};
      `MSSUP_ADDR_LOCALCMD: prdata = localcmd;
      default: begin
        addr_ok = 1'b0;
        prdata  = 32'h0000_0000;
      end
    endcase
  end
  assign pslverr = psel & penable & ~addr_ok;

  // Control register: bit 0 forces manual mode
  // Unused bits read back zero so software cannot park state in them.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctrl <= `MSSUP_CTRL_RESET;
    end else if (apb_wr && paddr == `MSSUP_ADDR_CTRL) begin
      ctrl <= {31'h00000000, pwdata[0]};
    end
  end

  // Optical channel commands: cw, ccw, and a self-clearing reset in bit 2
  // The reset bit lasts one cycle so a forgotten write cannot hold the
  // acknowledge on; the run bits stay until software rewrites them.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      localcmd <= `MSSUP_LOCALCMD_RESET;
    end else if (apb_wr && paddr == `MSSUP_ADDR_LOCALCMD) begin
      localcmd <= {29'h00000000, pwdata[2:0]};
    end else begin
      localcmd <= {localcmd[31:3], 1'b0, localcmd[1:0]};
    end
  end
endmodule // mssup_top
`default_nettype wire

/* design/mssup_defines.svh */
// Purpose: Constants for the motor starter fault supervisor
// Assumes: Included by its bare name
// Notes:   Offsets are byte addresses of aligned 32-bit words
`ifndef MSSUP_DEFINES_SVH
`define MSSUP_DEFINES_SVH
`define MSSUP_ADDR_CTRL      12'h000
`define MSSUP_ADDR_STATUS    12'h004
`define MSSUP_ADDR_FAULT     12'h008
`define MSSUP_ADDR_ALARM     12'h00c
`define MSSUP_ADDR_DIAG      12'h010
`define MSSUP_ADDR_LOCALCMD  12'h014
`define MSSUP_CTRL_RESET     32'h0000_0000
`define MSSUP_LOCALCMD_RESET 32'h0000_0000
// Fault bit positions
`define MSSUP_F_BREAKER      0
`define MSSUP_F_PROT         1
`define MSSUP_F_DEVICE       2
`define MSSUP_F_EXT          3
`define MSSUP_NFAULT         4
// Self-test duration and cyclic period, in cycles
`define MSSUP_SELFTEST_CYC   16'h0010
`define MSSUP_CYCLIC_CYC     16'h0100
`endif

/* design/mssup_pkg.sv */
// Purpose: Types for the motor starter fault supervisor
// Assumes: Nothing beyond the defines header
// Notes:   Control source selection and self-test states
package mssup_pkg;
  typedef enum logic [1:0] {
    MSSUP_SRC_NONE   = 2'b00,
    MSSUP_SRC_BUS    = 2'b01,
    MSSUP_SRC_KEYPAD = 2'b10,
    MSSUP_SRC_OPTIC  = 2'b11
  } mssup_src_t;
  typedef enum logic [1:0] {
    MSSUP_ST_START = 2'b00,
    MSSUP_ST_RUN   = 2'b01,
    MSSUP_ST_FAIL  = 2'b10
  } mssup_st_t;
endpackage

/* tb/mssup_asserts.sv */
// Purpose: Port-level checker for mssup_top
// Assumes: Outputs follow their causes one mclk later
// Notes:   Bound to every mssup_top instance
`timescale 1ns/1ps
`default_nettype none
module mssup_asserts
  import mssup_pkg::*;
(
  input wire logic       mclk,
  input wire logic       sys_rst,
  input wire logic       breaker_off,
  input wire logic       key_manual,
  input wire logic       key_off,
  input wire logic       optic_active,
  input wire logic       bus_online,
  input wire logic       temp_sensor_en,
  input wire logic       thermal_class_en,
  input wire logic       output_bit_two_quickstop_disable,
  input wire mssup_src_t ctrl_src,
  input wire logic       group_fault,
  input wire logic       group_alarm,
  input wire logic       internal_shutdown,
  input wire logic       device_led_red,
  input wire logic       ready_auto,
  input wire logic       manual_local_diag,
  input wire logic       quickstop_active
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // Each output is tied to the input that caused it, but shutdown to group fault and the red led to itself
  a_breaker_fault: assert property (breaker_off |=> group_fault)
    else $error("breaker off without group fault");
  a_optic_first: assert property (key_manual && optic_active && !key_off
    |=> ctrl_src == MSSUP_SRC_OPTIC) else $error("optic not obeyed");
  a_manual_diag: assert property (key_manual && !key_off |=> manual_local_diag)
    else $error("manual diagnostic missing");
  a_alarm_cause: assert property ($rose(group_alarm)
    |-> !$past(temp_sensor_en) && !$past(thermal_class_en)) else $error("stray alarm");
  a_ready_auto: assert property (ready_auto
    |-> $past(bus_online) && !$past(key_manual)) else $error("ready too early");
  a_shutdown_fault: assert property (internal_shutdown |-> group_fault)
    else $error("shutdown without fault");
  a_led_sticky: assert property (device_led_red |=> device_led_red)
    else $error("device led cleared");
  a_qs_disable: assert property (output_bit_two_quickstop_disable |=> ##1 !quickstop_active)
    else $error("quick stop not freed");
endmodule // mssup_asserts
bind mssup_top mssup_asserts u_chk (.mclk, .sys_rst, .breaker_off, .key_manual, .key_off,
  .optic_active, .bus_online, .temp_sensor_en, .thermal_class_en,
  .output_bit_two_quickstop_disable, .ctrl_src, .group_fault, .group_alarm,
  .internal_shutdown, .device_led_red, .ready_auto, .manual_local_diag, .quickstop_active);
`default_nettype wire

/* tb/mssup_bus_master.sv */
// Purpose: Fieldbus master model writing the output process image
// Assumes: Requests come from the bench one cycle ahead
// Notes:   No reset; outputs start low so the wire is never unknown
`timescale 1ns/1ps
`default_nettype none
module mssup_bus_master (
  input wire logic       mclk,
  input wire logic [1:0] run_req,
  input wire logic       reset_req,
  input wire logic       qsd_req,
  input wire logic       online_req,
  input wire logic       device_led_red,
  output logic           bus_cw_on = 1'h0,
  output logic           bus_ccw_on = 1'h0,
  output logic           output_bit_two_quickstop_disable = 1'h0,
  output logic           bus_online = 1'h0,
  output logic           upstream_open = 1'h0
);
  // Reset is both run bits at once, so it overrides any run request
  always_ff @(posedge mclk) begin
    bus_cw_on <= reset_req | run_req[0];
    bus_ccw_on <= reset_req | run_req[1];
    output_bit_two_quickstop_disable <= qsd_req;
    bus_online <= online_req;
    upstream_open <= device_led_red;
  end
endmodule // mssup_bus_master
`default_nettype wire

/* tb/tb_top.sv */
// Purpose: Self-checking bench for mssup_top
// Assumes: Bus master model drives the run bits
// Notes:   Checks settle three cycles after a direct stimulus, four after a bus master request
`timescale 1ns/1ps
`default_nettype none
`include "mssup_defines.svh"
module tb_top;
  import mssup_pkg::*;
  logic mclk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd_q;
  logic pready, pslverr, rd_e, key_manual = 0, key_off = 0, keypad_cw = 0, keypad_ccw = 0;
  logic optic_active = 0, optic_cw = 0, optic_ccw = 0, optic_reset = 0, breaker_off = 0;
  logic comp_fail = 0, selftest_fail = 0, ext_fault = 0, input_one = 0;
  logic temp_sensor_en = 1, thermal_class_en = 1, reset_req = 0, qsd_req = 0, online_req = 1;
  logic [1:0] run_req = 0, input_process_image;
  logic bus_cw_on, bus_ccw_on, output_bit_two_quickstop_disable, bus_online, upstream_open;
  logic motor_cw, motor_ccw, internal_shutdown, group_fault, group_alarm, device_led_red;
  logic ready_auto, manual_local_diag, quickstop_active;
  mssup_src_t ctrl_src;
  int fail_count = 0, num_checks = 0;
  mssup_top dut (.mclk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .bus_cw_on, .bus_ccw_on, .output_bit_two_quickstop_disable,
    .bus_online, .key_manual, .key_off, .keypad_cw, .keypad_ccw, .optic_active, .optic_cw,
    .optic_ccw, .optic_reset, .breaker_off, .temp_sensor_en, .thermal_class_en, .comp_fail,
    .selftest_fail, .ext_fault, .input_one, .ctrl_src, .motor_cw, .motor_ccw,
    .internal_shutdown, .group_fault, .group_alarm, .device_led_red, .ready_auto,
    .manual_local_diag, .quickstop_active, .input_process_image);
  mssup_bus_master u_master (.mclk, .run_req, .reset_req, .qsd_req, .online_req,
    .device_led_red, .bus_cw_on, .bus_ccw_on, .output_bit_two_quickstop_disable,
    .bus_online, .upstream_open);
  // Free-running 100 MHz clock
  initial forever #5 mclk = ~mclk;
  task automatic ck(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // One APB transfer; data is taken at the edge that sees pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    rd_q = prdata;
    rd_e = pslverr;
    if (n >= 50) begin
      fail_count++;
      give_verdict;
    end
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge mclk);
  endtask
  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] e,
                    input logic ee);
    apb(1'h0, a, 32'h0);
    ck(nm, e, rd_q);
    ck("pslverr", {31'h0, ee}, {31'h0, rd_e});
  endtask
  // Hang guard
  initial begin
    cyc(20000);
    fail_count++;
    give_verdict;
  end
  // Main sequence
  initial begin
    cyc(20);
    sys_rst <= 1'h0;
    cyc(20);
    ck("fault", 0, group_fault);
    ck("src", MSSUP_SRC_BUS, ctrl_src);
    ck("ready", 1, ready_auto);
    rd("ctrl", `MSSUP_ADDR_CTRL, `MSSUP_CTRL_RESET, 1'h0);
    apb(1'h1, `MSSUP_ADDR_CTRL, 32'h1);
    cyc(2);
    ck("sw_man", MSSUP_SRC_KEYPAD, ctrl_src);
    apb(1'h1, `MSSUP_ADDR_CTRL, 32'h0);
    rd("hole", 12'h0f0, 32'h0, 1'h1);
    keypad_cw <= 1'h1;
    cyc(3);
    ck("kp_auto", 0, motor_cw);
    key_manual <= 1'h1;
    cyc(3);
    ck("kp_src", MSSUP_SRC_KEYPAD, ctrl_src);
    ck("kp_run", 1, motor_cw);
    ck("ready_m", 0, ready_auto);
    rd("diag", `MSSUP_ADDR_DIAG, 32'h4, 1'h0);
    optic_active <= 1'h1;
    optic_ccw <= 1'h1;
    cyc(3);
    ck("op_cw", 0, motor_cw);
    ck("op_ccw", 1, motor_ccw);
    optic_ccw <= 1'h0;
    apb(1'h1, `MSSUP_ADDR_LOCALCMD, 32'h1);
    cyc(3);
    ck("lc_cw", 1, motor_cw);
    rd("lcmd", `MSSUP_ADDR_LOCALCMD, 32'h1, 1'h0);
    rd("stat", `MSSUP_ADDR_STATUS, 32'h43, 1'h0);
    apb(1'h1, `MSSUP_ADDR_LOCALCMD, 32'h0);
    {key_manual, keypad_cw, optic_active, optic_ccw} <= 4'h0;
    run_req <= 2'h1;
    cyc(4);
    ck("qs_pre", 1, motor_cw);
    input_one <= 1'h1;
    cyc(4);
    ck("qs", 1, quickstop_active);
    ck("qs_stop", 0, motor_cw);
    qsd_req <= 1'h1;
    cyc(4);
    ck("qs_run", 1, motor_cw);
    ck("free_in", 1, input_process_image[0]);
    {run_req, input_one, qsd_req} <= 4'h0;
    breaker_off <= 1'h1;
    cyc(3);
    ck("brk", 1, group_fault);
    rd("flt", `MSSUP_ADDR_FAULT, 32'h1, 1'h0);
    reset_req <= 1'h1;
    cyc(4);
    ck("brk_held", 1, group_fault);
    ck("no_run", 0, motor_cw | motor_ccw);
    reset_req <= 1'h0;
    cyc(3);
    breaker_off <= 1'h0;
    cyc(4);
    ck("sticky", 1, group_fault);
    reset_req <= 1'h1;
    cyc(4);
    ck("bus_rst", 0, group_fault);
    reset_req <= 1'h0;
    ext_fault <= 1'h1;
    cyc(3);
    ck("ext", 1, group_fault);
    rd("flt_ext", `MSSUP_ADDR_FAULT, 32'h8, 1'h0);
    ext_fault <= 1'h0;
    key_off <= 1'h1;
    cyc(3);
    ck("key_rst", 0, group_fault);
    key_off <= 1'h0;
    {temp_sensor_en, thermal_class_en} <= 2'h0;
    cyc(3);
    ck("p_alarm", 1, group_alarm);
    rd("alm", `MSSUP_ADDR_ALARM, 32'h1, 1'h0);
    run_req <= 2'h1;
    cyc(4);
    ck("p_fault", 1, group_fault);
    ck("p_shut", 1, internal_shutdown);
    optic_reset <= 1'h1;
    cyc(3);
    optic_reset <= 1'h0;
    cyc(3);
    ck("p_held", 1, group_fault);
    temp_sensor_en <= 1'h1;
    optic_reset <= 1'h1;
    cyc(3);
    optic_reset <= 1'h0;
    cyc(3);
    ck("p_ack", 0, group_fault);
    temp_sensor_en <= 1'h0;
    cyc(3);
    run_req <= 2'h0;
    cyc(4);
    ck("p_down", 0, group_fault);
    ck("p_alm2", 1, group_alarm);
    temp_sensor_en <= 1'h1;
    thermal_class_en <= 1'h1;
    comp_fail <= 1'h1;
    cyc(300);
    comp_fail <= 1'h0;
    rd("dev", `MSSUP_ADDR_FAULT, 32'h4, 1'h0);
    sys_rst <= 1'h1;
    selftest_fail <= 1'h1;
    cyc(20);
    sys_rst <= 1'h0;
    cyc(20);
    selftest_fail <= 1'h0;
    key_off <= 1'h1;
    cyc(3);
    key_off <= 1'h0;
    cyc(3);
    ck("led", 1, device_led_red);
    ck("upstream", 1, upstream_open);
    sys_rst <= 1'h1;
    cyc(20);
    sys_rst <= 1'h0;
    cyc(20);
    ck("led_off", 0, device_led_red);
    give_verdict;
  end
endmodule // tb_top
`default_nettype wire
